// File: design/hbt_pkg.sv
package hbt_pkg;
  // Control and status addresses of this block
  localparam logic [11:0] HBT_CSR_TSEL = 12'h7A0;
  localparam logic [11:0] HBT_CSR_TD1 = 12'h7A1;
  localparam logic [11:0] HBT_CSR_TD2 = 12'h7A2;
  localparam logic [11:0] HBT_CSR_TD3 = 12'h7A3;
  localparam logic [11:0] HBT_CSR_DCSR = 12'h7B0;
  localparam logic [11:0] HBT_CSR_DPC = 12'h7B1;
  localparam logic [11:0] HBT_CSR_DSCR = 12'h7B2;

  localparam int HBT_NUM_BP = 2;
  localparam logic [31:0] HBT_NUM_BP_W = 32'h0000_0002;

  // Match control field positions
  localparam int HBT_B_LOAD = 0;
  localparam int HBT_B_STORE = 1;
  localparam int HBT_B_FETCH = 2;
  localparam int HBT_B_USER = 3;
  localparam int HBT_B_SUP = 4;
  localparam int HBT_B_MACH = 6;
  localparam int HBT_B_MATCH_LO = 7;
  localparam int HBT_B_CHAIN = 11;
  localparam int HBT_B_ACT_LO = 12;
  localparam int HBT_B_DMODE = 27;

  localparam logic [3:0] HBT_TYPE_NONE = 4'h0;
  localparam logic [3:0] HBT_TYPE_MATCH = 4'h2;
  localparam logic [5:0] HBT_MASKMAX = 6'h04;
  localparam logic [5:0] HBT_ACT_EXC = 6'h00;
  localparam logic [5:0] HBT_ACT_DBG = 6'h01;
  localparam logic [3:0] HBT_MATCH_EQ = 4'h0;
  localparam logic [3:0] HBT_MATCH_NAPOT = 4'h1;
  localparam logic [3:0] HBT_MATCH_GE = 4'h2;
  localparam logic [3:0] HBT_MATCH_LT = 4'h3;
  localparam logic [1:0] HBT_PRIV_U = 2'h0;
  localparam logic [1:0] HBT_PRIV_S = 2'h1;
  localparam logic [1:0] HBT_PRIV_M = 2'h3;
  localparam logic [31:0] HBT_RST_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {HBT_K_LOAD, HBT_K_STORE, HBT_K_FETCH} hbt_kind_t;

  typedef struct packed {
    logic load;
    logic store;
    logic fetch;
    logic user;
    logic sup;
    logic mach;
    logic [3:0] match;
    logic chain;
    logic [5:0] action;
    logic dmode;
  } hbt_mctl_t;

  localparam hbt_mctl_t HBT_MCTL_RST = '0;

  typedef struct packed {
    logic valid;
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
  } hbt_csr_req_t;

  typedef struct packed {
    logic valid;
    hbt_kind_t kind;
    logic [1:0] priv;
    logic [31:0] addr;
    logic [1:0] size;
  } hbt_acc_t;
endpackage

// File: design/hbt_trigger_csr.sv
// Contract
// R01 - Debug registers need debug mode; select and trigger data need debug or machine.
// R02 - Select value chooses which breakpoint bank appears at trigger data addresses.
// R03 - Select index keeps only implemented indices; writes of others are refused.
// R04 - Type nibble of first data register: 0 absent, 2 address match.
// R05 - Exactly two breakpoints per hart, shared by debug and machine mode.
// R06 - First data is match control, second match address, third reserved.
// R07 - Machine access to a debug-only breakpoint's data registers is illegal.
// R08 - Debug entry captures PC; resume address is the held debug PC.
// R09 - Action field legal values 0 exception and 1 debug; reset 0.
// R10 - Load, store, fetch bits restrict matching; any combination works.
// R11 - Machine, supervisor, user bits restrict matching; bit 5 reserved.
// R12 - Match type selects exact, power-of-two, or chained range compare.
// R13 - Power-of-two size comes from trailing ones of the match address.
// R14 - Read-only field reports largest power-of-two range log, value 4.
// R15 - Widest encoding compares only address bit 31.
// R16 - Chained range: lower breakpoint bottom, higher one past top.
// R17 - With chain set, second fires only when both comparisons hold.
// R18 - Timing and select bits always read zero.
// R19 - Match control type field returns 2, except where R21 hides it as 0.
// R20 - Debug traps are separate from exceptions and signalled precisely.
// R21 - Breakpoint held by debug mode reads type 0 to machine mode.
// R22 - Any byte of a multi-byte access inside the range hits.
// R23 - Reserved bits read zero; debug scratch stores written data.
`timescale 1ns/1ps
module hbt_trigger_csr
  import hbt_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Register access from the hart
  input wire hbt_csr_req_t i_csr,
  input wire logic i_debug_mode,
  input wire logic [1:0] i_priv,
  output logic o_csr_ack,
  output logic o_csr_illegal,
  output logic [31:0] o_csr_rdata,
  // Memory access observed for matching
  input wire hbt_acc_t i_acc,
  output logic o_bp_exc,
  output logic o_bp_debug,
  output logic [31:0] o_bp_addr,
  // Debug entry and resume
  input wire logic i_dbg_enter,
  input wire logic [31:0] i_pc,
  output logic [31:0] o_resume_pc
);

  logic sel_q;
  hbt_mctl_t mc_q [HBT_NUM_BP]; // [R05]
  logic [31:0] maddr_q [HBT_NUM_BP];
  logic [31:0] dcsr_q;
  logic [31:0] dscratch_q;

  logic is_trig, is_td, is_dbg, lock, illegal, wr_ok;
  logic [31:0] rdata;
  logic hit0, hit1, fire;
  logic [5:0] fire_act;

  // Trailing ones of the address plus the next bit are don't-care
  function automatic logic [31:0] napot_mask(input logic [31:0] ma);
    logic [31:0] m;
    logic run;
    m = '0;
    run = 1'b1;
    for (int i = 0; i < 32; i++) begin
      if (run) begin
        m[i] = 1'b1; // [R13] [R15]
      end
      if (!ma[i]) begin
        run = 1'b0;
      end
    end
    return m;
  endfunction

  function automatic logic [31:0] mctl_word(input hbt_mctl_t m, input logic hide);
    logic [31:0] w;
    w = '0;
    w[31:28] = hide ? HBT_TYPE_NONE : HBT_TYPE_MATCH; // [R04] [R19] [R21]
    w[HBT_B_DMODE] = m.dmode;
    w[26:21] = HBT_MASKMAX; // [R14]
    w[HBT_B_ACT_LO +: 6] = m.action;
    w[HBT_B_CHAIN] = m.chain;
    w[HBT_B_MATCH_LO +: 4] = m.match;
    w[HBT_B_MACH] = m.mach;
    w[HBT_B_SUP] = m.sup;
    w[HBT_B_USER] = m.user;
    w[HBT_B_FETCH] = m.fetch;
    w[HBT_B_STORE] = m.store;
    w[HBT_B_LOAD] = m.load;
    return w; // bits 5, 18, 19, 20 stay zero [R18] [R23]
  endfunction

  function automatic hbt_mctl_t mctl_legal(input logic [31:0] w, input hbt_mctl_t old,
                                           input logic dbg);
    hbt_mctl_t m;
    m.load = w[HBT_B_LOAD]; // [R10]
    m.store = w[HBT_B_STORE];
    m.fetch = w[HBT_B_FETCH];
    m.user = w[HBT_B_USER]; // [R11]
    m.sup = w[HBT_B_SUP];
    m.mach = w[HBT_B_MACH];
    m.match = (w[HBT_B_MATCH_LO +: 4] <= HBT_MATCH_LT) ? w[HBT_B_MATCH_LO +: 4]
                                                     : HBT_MATCH_EQ; // [R12]
    m.chain = w[HBT_B_CHAIN];
    m.action = (w[HBT_B_ACT_LO +: 6] == HBT_ACT_DBG) ? HBT_ACT_DBG : HBT_ACT_EXC; // [R09]
    // Only debug code may claim or release a breakpoint
    m.dmode = dbg ? w[HBT_B_DMODE] : old.dmode;
    return m;
  endfunction

  function automatic logic bp_hit(input hbt_mctl_t m, input logic [31:0] ma,
                                  input hbt_acc_t a);
    logic kind_ok, priv_ok, addr_ok;
    logic [31:0] mask;
    logic [32:0] lo, hi, a_lo, a_hi;
    mask = (m.match == HBT_MATCH_NAPOT) ? napot_mask(ma) : '0;
    lo = {1'b0, ma & ~mask};
    hi = {1'b0, ma | mask};
    a_lo = {1'b0, a.addr};
    a_hi = a_lo + ((33'h1 << a.size) - 33'h1); // [R22]
    case (a.kind)
      HBT_K_LOAD: kind_ok = m.load; // [R10]
      HBT_K_STORE: kind_ok = m.store;
      HBT_K_FETCH: kind_ok = m.fetch;
      default: kind_ok = 1'b0;
    endcase
    case (a.priv)
      HBT_PRIV_U: priv_ok = m.user; // [R11]
      HBT_PRIV_S: priv_ok = m.sup;
      HBT_PRIV_M: priv_ok = m.mach;
      default: priv_ok = 1'b0;
    endcase
    case (m.match)
      HBT_MATCH_EQ, HBT_MATCH_NAPOT: addr_ok = (a_hi >= lo) && (a_lo <= hi); // [R12] [R22]
      HBT_MATCH_GE: addr_ok = a_hi >= {1'b0, ma};
      HBT_MATCH_LT: addr_ok = a_lo < {1'b0, ma};
      default: addr_ok = 1'b0;
    endcase
    return a.valid && kind_ok && priv_ok && addr_ok;
  endfunction

  // Access decode and read mux
  always_comb begin
    is_td = (i_csr.addr == HBT_CSR_TD1) || (i_csr.addr == HBT_CSR_TD2)
            || (i_csr.addr == HBT_CSR_TD3);
    is_trig = is_td || (i_csr.addr == HBT_CSR_TSEL);
    is_dbg = (i_csr.addr == HBT_CSR_DCSR) || (i_csr.addr == HBT_CSR_DPC)
             || (i_csr.addr == HBT_CSR_DSCR);
    lock = is_td && !i_debug_mode && mc_q[sel_q].dmode; // [R07]
    illegal = is_dbg ? !i_debug_mode // [R01]
            : is_trig ? !(i_debug_mode || i_priv == HBT_PRIV_M) || lock
            : 1'b1;
    wr_ok = i_csr.valid && i_csr.we && !illegal;
    case (i_csr.addr)
      HBT_CSR_TSEL: rdata = {31'h0, sel_q};
      HBT_CSR_TD1: rdata = mctl_word(mc_q[sel_q], lock); // [R02] [R06]
      HBT_CSR_TD2: rdata = maddr_q[sel_q];
      HBT_CSR_TD3: rdata = HBT_RST_WORD; // [R06]
      HBT_CSR_DCSR: rdata = dcsr_q;
      HBT_CSR_DPC: rdata = o_resume_pc;
      HBT_CSR_DSCR: rdata = dscratch_q;
      default: rdata = HBT_RST_WORD;
    endcase
  end

  // Register answer, one cycle after the request
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_csr_ack <= 1'b0;
      o_csr_illegal <= 1'b0;
      o_csr_rdata <= HBT_RST_WORD;
    end else begin
      o_csr_ack <= i_csr.valid;
      o_csr_illegal <= i_csr.valid && illegal;
      o_csr_rdata <= (i_csr.valid && !illegal) ? rdata : HBT_RST_WORD;
    end
  end

  // Select index: out-of-range writes leave the old index in place
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q <= 1'b0;
    end else if (wr_ok && i_csr.addr == HBT_CSR_TSEL && i_csr.wdata < HBT_NUM_BP_W) begin
      sel_q <= i_csr.wdata[0]; // [R03]
    end
  end

  // Breakpoint banks
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < HBT_NUM_BP; i++) begin
        mc_q[i] <= HBT_MCTL_RST;
        maddr_q[i] <= HBT_RST_WORD;
      end
    end else if (wr_ok && i_csr.addr == HBT_CSR_TD1) begin
      mc_q[sel_q] <= mctl_legal(i_csr.wdata, mc_q[sel_q], i_debug_mode); // [R02]
    end else if (wr_ok && i_csr.addr == HBT_CSR_TD2) begin
      maddr_q[sel_q] <= i_csr.wdata;
    end
  end

  // Debug-only registers; debug entry wins over a software write of the PC
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_resume_pc <= HBT_RST_WORD;
      dcsr_q <= HBT_RST_WORD;
      dscratch_q <= HBT_RST_WORD;
    end else begin
      if (i_dbg_enter) begin
        o_resume_pc <= i_pc; // [R08]
      end else if (wr_ok && i_csr.addr == HBT_CSR_DPC) begin
        o_resume_pc <= i_csr.wdata;
      end
      if (wr_ok && i_csr.addr == HBT_CSR_DCSR) begin
        dcsr_q <= i_csr.wdata;
      end
      if (wr_ok && i_csr.addr == HBT_CSR_DSCR) begin
        dscratch_q <= i_csr.wdata; // [R23]
      end
    end
  end

  // Match and chaining: a chained pair acts with the upper breakpoint's action
  always_comb begin
    hit0 = bp_hit(mc_q[0], maddr_q[0], i_acc);
    hit1 = bp_hit(mc_q[1], maddr_q[1], i_acc);
    if (mc_q[0].chain) begin
      fire = hit0 && hit1; // [R16] [R17]
      fire_act = mc_q[1].action;
    end else begin
      fire = hit0 || hit1;
      fire_act = hit0 ? mc_q[0].action : mc_q[1].action;
    end
  end

  // Registered trap request, raised the cycle after the matching access
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bp_exc <= 1'b0;
      o_bp_debug <= 1'b0;
      o_bp_addr <= HBT_RST_WORD;
    end else begin
      o_bp_exc <= fire && fire_act == HBT_ACT_EXC; // [R09]
      o_bp_debug <= fire && fire_act == HBT_ACT_DBG; // [R20]
      if (fire) begin
        o_bp_addr <= i_acc.addr;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  dbg_priv_a: assert property ( // [R01]
    i_csr.valid && is_dbg && !i_debug_mode |=> o_csr_ack && o_csr_illegal)
    else $error("debug register reached outside debug mode");

  trig_mach_a: assert property ( // [R01]
    i_csr.valid && is_trig && i_priv == HBT_PRIV_M && !lock |=> !o_csr_illegal)
    else $error("machine access to trigger register refused");

  sel_refuse_a: assert property ( // [R03]
    i_csr.valid && i_csr.we && i_csr.addr == HBT_CSR_TSEL && i_csr.wdata >= HBT_NUM_BP_W
    |=> $stable(sel_q))
    else $error("select index took an unimplemented value");

  dmode_trap_a: assert property ( // [R07]
    i_csr.valid && is_td && !i_debug_mode && mc_q[sel_q].dmode |=> o_csr_illegal)
    else $error("machine access to debug-only breakpoint allowed");

  dpc_capture_a: assert property ( // [R08]
    i_dbg_enter |=> o_resume_pc == $past(i_pc))
    else $error("debug PC did not capture PC");

  action_legal_a: assert property ( // [R09]
    mc_q[0].action <= HBT_ACT_DBG && mc_q[1].action <= HBT_ACT_DBG)
    else $error("illegal action value stored");

  chain_block_a: assert property ( // [R17]
    mc_q[0].chain && !(hit0 && hit1) |=> !o_bp_exc && !o_bp_debug)
    else $error("chained breakpoint fired without both matches");

  type_read_a: assert property ( // [R19]
    i_csr.valid && i_csr.addr == HBT_CSR_TD1 && !illegal
    |=> o_csr_rdata[31:28] == HBT_TYPE_MATCH && o_csr_rdata[26:21] == HBT_MASKMAX
        && o_csr_rdata[20:18] == 3'h0 && !o_csr_rdata[5])
    else $error("fixed match control fields wrong");

  td3_zero_a: assert property ( // [R06]
    i_csr.valid && i_csr.addr == HBT_CSR_TD3 |=> o_csr_rdata == HBT_RST_WORD)
    else $error("reserved third data register read nonzero");

  // A claimed breakpoint must not leak its type to machine code
  hide_type_a: assert property ( // [R21]
    i_csr.valid && lock |=> o_csr_rdata[31:28] == HBT_TYPE_NONE)
    else $error("claimed breakpoint visible to machine mode");

  exc_cov: cover property (o_bp_exc);
  napot_cov: cover property (o_bp_exc && mc_q[0].match == HBT_MATCH_NAPOT);
  dbg_cov: cover property (o_bp_debug);
  chain_cov: cover property (mc_q[0].chain && hit0 && hit1);
  illegal_cov: cover property (o_csr_illegal);

endmodule

// File: tb/hbt_hart_model.sv
`timescale 1ns/1ps
module hbt_hart_model
  import hbt_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Request from the bench
  input wire hbt_acc_t i_req,
  // Access presented to the trigger block
  output hbt_acc_t o_acc
);
  // Idle cycles flip the address so that nothing can lean on a stale bus
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_acc <= '0;
    end else if (i_req.valid) begin
      o_acc <= i_req;
    end else begin
      o_acc.valid <= 1'b0;
      o_acc.addr <= ~o_acc.addr;
    end
  end
endmodule

// File: tb/hbt_trigger_csr_test.sv
`timescale 1ns/1ps
module hbt_trigger_csr_test
  import hbt_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  hbt_csr_req_t csr_q = '0;
  hbt_acc_t req_q = '0;
  hbt_acc_t acc;
  logic dbg_q = 1'b0;
  logic [1:0] prv_q = HBT_PRIV_M;
  logic enter_q = 1'b0;
  logic [31:0] pc_q = '0;
  logic ack, ill, bp_exc, bp_dbg;
  logic [31:0] rdata, bp_addr, resume_pc;
  int err_count = 0;
  int num_checks = 0;

  always #5 i_mclk = ~i_mclk;

  hbt_hart_model i_hart (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(req_q), .o_acc(acc));

  hbt_trigger_csr i_dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_csr(csr_q), .i_debug_mode(dbg_q),
    .i_priv(prv_q), .o_csr_ack(ack), .o_csr_illegal(ill), .o_csr_rdata(rdata),
    .i_acc(acc), .o_bp_exc(bp_exc), .o_bp_debug(bp_dbg), .o_bp_addr(bp_addr),
    .i_dbg_enter(enter_q), .i_pc(pc_q), .o_resume_pc(resume_pc)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic mode(input logic d, input logic [1:0] p);
    @(posedge i_mclk);
    dbg_q <= d;
    prv_q <= p;
  endtask

  // Read data is compared on reads only; refused accesses must read 0
  task automatic csr(input logic we, input logic [11:0] a, input logic [31:0] wd,
                     input logic exp_ill, input logic [31:0] exp);
    @(posedge i_mclk);
    csr_q <= '{valid: 1'b1, we: we, addr: a, wdata: wd};
    @(posedge i_mclk);
    csr_q.valid <= 1'b0;
    #1;
    check(32'(ack), 32'h1);
    check(32'(ill), 32'(exp_ill));
    if (!we) begin
      check(rdata, exp);
    end
  endtask

  task automatic hit(input hbt_kind_t k, input logic [1:0] p, input logic [31:0] a,
                     input logic [1:0] sz, input logic e_exc, input logic e_dbg);
    @(posedge i_mclk);
    req_q <= '{valid: 1'b1, kind: k, priv: p, addr: a, size: sz};
    @(posedge i_mclk);
    req_q.valid <= 1'b0;
    @(posedge i_mclk);
    #1;
    check({30'h0, bp_exc, bp_dbg}, {30'h0, e_exc, e_dbg});
    if (e_exc || e_dbg) begin
      check(bp_addr, a);
    end
  endtask

  initial begin
    #50000;
    err_count++;
    finish_test;
  end

  initial begin
    repeat (16) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    csr(0, HBT_CSR_TSEL, 0, 0, 32'h0);
    csr(0, HBT_CSR_TD1, 0, 0, 32'h2080_0000);
    csr(0, HBT_CSR_TD2, 0, 0, 32'h0);
    csr(0, HBT_CSR_DPC, 0, 1, 32'h0);
    csr(0, HBT_CSR_DCSR, 0, 1, 32'h0);
    csr(1, HBT_CSR_TSEL, 32'h5, 0, 0);
    csr(0, HBT_CSR_TSEL, 0, 0, 32'h0);
    csr(1, HBT_CSR_TSEL, 32'h1, 0, 0);
    csr(0, HBT_CSR_TSEL, 0, 0, 32'h1);
    csr(1, HBT_CSR_TD2, 32'hABC, 0, 0);
    csr(1, HBT_CSR_TD1, 32'h0A, 0, 0);
    csr(1, HBT_CSR_TD3, 32'h55, 0, 0);
    csr(0, HBT_CSR_TD3, 0, 0, 32'h0);
    csr(1, HBT_CSR_TSEL, 32'h0, 0, 0);
    csr(0, HBT_CSR_TD2, 0, 0, 32'h0);
    mode(0, HBT_PRIV_U);
    csr(0, HBT_CSR_TSEL, 0, 1, 32'h0);
    mode(1, HBT_PRIV_M);
    csr(0, 12'h7FF, 0, 1, 32'h0);
    csr(1, HBT_CSR_DCSR, 32'h0000_0F0F, 0, 0);
    csr(0, HBT_CSR_DCSR, 0, 0, 32'h0000_0F0F);
    csr(1, HBT_CSR_DSCR, 32'h5A5A_C3C3, 0, 0);
    csr(0, HBT_CSR_DSCR, 0, 0, 32'h5A5A_C3C3);
    csr(1, HBT_CSR_TD1, 32'hFFFF_FFFF, 0, 0);
    csr(0, HBT_CSR_TD1, 0, 0, 32'h2880_085F);
    mode(0, HBT_PRIV_M);
    csr(0, HBT_CSR_TD1, 0, 1, 32'h0);
    csr(1, HBT_CSR_TD2, 32'h5, 1, 0);
    mode(1, HBT_PRIV_M);
    csr(1, HBT_CSR_TD1, 32'h0, 0, 0);
    csr(0, HBT_CSR_TD2, 0, 0, 32'h0);
    mode(0, HBT_PRIV_M);
    csr(1, HBT_CSR_TD2, 32'h100, 0, 0);
    csr(1, HBT_CSR_TD1, 32'h41, 0, 0);
    // The upper breakpoint still holds the store and user setup from above
    hit(HBT_K_STORE, HBT_PRIV_U, 32'hABC, 2'h0, 1, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h100, 2'h0, 1, 0);
    hit(HBT_K_STORE, HBT_PRIV_M, 32'h100, 2'h0, 0, 0);
    hit(HBT_K_FETCH, HBT_PRIV_M, 32'h100, 2'h0, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_U, 32'h100, 2'h0, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_S, 32'h100, 2'h0, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h101, 2'h0, 0, 0);
    csr(1, HBT_CSR_TD1, 32'h1041, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h100, 2'h0, 0, 1);
    csr(1, HBT_CSR_TD2, 32'h10B, 0, 0);
    csr(1, HBT_CSR_TD1, 32'hC1, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h10F, 2'h0, 1, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h110, 2'h0, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h107, 2'h0, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h107, 2'h1, 1, 0);
    csr(1, HBT_CSR_TD2, 32'h3FFF_FFFF, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h7FFF_FFF0, 2'h0, 1, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h8000_0000, 2'h0, 0, 0);
    // Software side of the chained pair: bottom on the lower breakpoint, one past top above
    csr(1, HBT_CSR_TD2, 32'h200, 0, 0);
    csr(1, HBT_CSR_TD1, 32'h941, 0, 0);
    csr(1, HBT_CSR_TSEL, 32'h1, 0, 0);
    csr(1, HBT_CSR_TD2, 32'h210, 0, 0);
    csr(1, HBT_CSR_TD1, 32'h11C1, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h208, 2'h0, 0, 1);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h210, 2'h0, 0, 0);
    hit(HBT_K_LOAD, HBT_PRIV_M, 32'h1F0, 2'h0, 0, 0);
    @(posedge i_mclk);
    enter_q <= 1'b1;
    pc_q <= 32'h0000_1234;
    @(posedge i_mclk);
    enter_q <= 1'b0;
    #1;
    check(resume_pc, 32'h0000_1234);
    mode(1, HBT_PRIV_M);
    csr(0, HBT_CSR_DPC, 0, 0, 32'h0000_1234);
    csr(1, HBT_CSR_DPC, 32'h0000_4000, 0, 0);
    check(resume_pc, 32'h0000_4000);
    finish_test;
  end
endmodule
